/* hw/ffth_defines.svh */
// Register offsets, field positions, reset values and scaling constants of the threshold block
`ifndef FFTH_DEFINES_SVH
`define FFTH_DEFINES_SVH
// Register indices; the APB byte address is four times the index
`define FFTH_IDX_XH 8'h73
`define FFTH_IDX_XL 8'h74
`define FFTH_IDX_YH 8'h75
`define FFTH_IDX_YL 8'h76
`define FFTH_IDX_ZH 8'h77
`define FFTH_IDX_ZL 8'h78
`define FFTH_IDX_CTRL 8'h80
`define FFTH_IDX_STAT 8'h81
`define FFTH_IDX_MASK 8'h82
`define FFTH_IDX_EVT 8'h83
`define FFTH_IDX_COUNT 8'h84
`define FFTH_ADDR(i) ({2'b00, (i), 2'b00})
// Field positions
`define FFTH_SEL_BIT 7
`define FFTH_CTRL_OAE 0
`define FFTH_CTRL_XEN 1
`define FFTH_CTRL_YEN 2
`define FFTH_CTRL_ZEN 3
`define FFTH_CTRL_DBCM 4
`define FFTH_CTRL_FS_LO 5
// Reset values
`define FFTH_REG_RESET 8'h00
// Common threshold weight, micro-g per step and per data LSB at 2g range
`define FFTH_COMMON_UG_PER_STEP 63000
`define FFTH_DATA_UG_PER_LSB_2G 244
`endif

/* hw/ffth_pkg.sv */
// Types of the threshold block
package ffth_pkg;
   typedef enum logic [2:0] {
      FFTH_IDLE = 3'b001,
      FFTH_SETUP = 3'b010,
      FFTH_ACCESS = 3'b100
   } ffth_bus_type;
   typedef struct packed {
      logic [7:0] xh;
      logic [7:0] xl;
      logic [7:0] yh;
      logic [7:0] yl;
      logic [7:0] zh;
      logic [7:0] zl;
      logic [6:0] common_ths;
      logic [6:0] common_transient_threshold;
      logic [7:0] ctrl;
      logic [7:0] count;
      logic [7:0] dbcnt;
      logic [1:0] status;
      logic [1:0] mask;
      logic ffmt_cond;
      logic trans_cond;
      logic ffmt_flag;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      ffth_bus_type bus;
   } ffth_state_type;
endpackage
`default_nettype wire

/* hw/ffth_top.sv */
// Freefall/motion and transient threshold select and compare block with APB registers
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ffth_defines.svh"

// How it works
// - With per-axis select clear, all three axes compare against the common 7-bit freefall/motion threshold.
// - The common threshold is an unsigned 0..127 count of 63 mg steps whatever the full-scale range.
// - With per-axis select set, each axis compares against its own threshold built from its high/low pair.
// - Per-axis thresholds are 13-bit unsigned values weighted like the output data at the current full scale.
// - With transient per-axis select clear, the transient compare uses its common 7-bit 63 mg threshold.
// - With transient per-axis select set, the transient compare uses the per-axis 13-bit thresholds.
// - Low-g mode detects an event only when every enabled axis is below its threshold.
// - High-g mode detects an event when any enabled axis exceeds its threshold.
// - Low-g and high-g combining is the same in common and per-axis mode.
// - X high holds the select bit in bit 7 and threshold bits 12..6; X low holds bits 5..0 in its top six bits.
// - Y high holds transient select in bit 7; Z high bit 7 is reserved; low registers hold bits 5..0 on top.
// - When the debounce counter reaches the programmed count the freefall/motion event flag is set.
module ffth_top (
   input wire logic pclk, // APB clock, 100 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic sample_valid, // One-cycle pulse: new sample at ODR
   input wire logic [13:0] accel_x, // X sample, two's complement
   input wire logic [13:0] accel_y, // Y sample, two's complement
   input wire logic [13:0] accel_z, // Z sample, two's complement
   output logic ffmt_detect, // Freefall/motion condition of last sample
   output logic transient_detect, // Transient threshold exceeded on last sample
   output logic ffmt_event, // Debounced freefall/motion event flag
   output logic irq // Level interrupt
);
   ffth_pkg::ffth_state_type st;
   ffth_pkg::ffth_state_type next_st;

   // Combinational helpers
   logic [1:0] fs;
   logic [12:0] ths_x;
   logic [12:0] ths_y;
   logic [12:0] ths_z;
   logic [12:0] common_scaled;
   logic [12:0] trans_scaled;
   logic [12:0] mag_x;
   logic [12:0] mag_y;
   logic [12:0] mag_z;
   logic [2:0] axis_en;
   logic [2:0] below;
   logic [2:0] above;
   logic [2:0] t_above;
   logic ffmt_now;
   logic trans_now;
   logic wr_en;
   logic rd_hit;
   logic [31:0] rd_data;

   // Absolute value of a 14-bit sample, saturated into 13 bits
   function automatic logic [12:0] abs13(input logic [13:0] v);
      logic [13:0] a;
      a = v[13] ? (14'h0000 - v) : v;
      abs13 = a[13] ? 13'h1fff : a[12:0];
   endfunction

   // Scale a 63 mg count into output-data LSBs for the selected range
   function automatic logic [12:0] scale63(input logic [6:0] c, input logic [1:0] r);
      logic [31:0] ug;
      logic [31:0] lsb;
      ug = 32'(c) * 32'(`FFTH_COMMON_UG_PER_STEP);
      lsb = 32'(`FFTH_DATA_UG_PER_LSB_2G) << r;
      ug = ug / lsb;
      scale63 = (ug > 32'h0000_1fff) ? 13'h1fff : ug[12:0];
   endfunction

   // Threshold selection and comparison
   always_comb begin
      fs = st.ctrl[`FFTH_CTRL_FS_LO +: 2];
      ths_x = {st.xh[6:0], st.xl[7:2]};
      ths_y = {st.yh[6:0], st.yl[7:2]};
      ths_z = {st.zh[6:0], st.zl[7:2]};
      common_scaled = scale63(st.common_ths, fs);
      trans_scaled = scale63(st.common_transient_threshold, fs);
      if (!st.xh[`FFTH_SEL_BIT]) begin
         ths_x = common_scaled;
         ths_y = common_scaled;
         ths_z = common_scaled;
      end
      mag_x = abs13(accel_x);
      mag_y = abs13(accel_y);
      mag_z = abs13(accel_z);
      axis_en = {st.ctrl[`FFTH_CTRL_ZEN], st.ctrl[`FFTH_CTRL_YEN], st.ctrl[`FFTH_CTRL_XEN]};
      below = {mag_z < ths_z, mag_y < ths_y, mag_x < ths_x};
      above = {mag_z > ths_z, mag_y > ths_y, mag_x > ths_x};
      // Same combining for common and per-axis thresholds
      if (st.ctrl[`FFTH_CTRL_OAE]) begin
         ffmt_now = |(above & axis_en);
      end else begin
         ffmt_now = (axis_en != 3'b000) && ((below | ~axis_en) == 3'b111);
      end
      if (st.yh[`FFTH_SEL_BIT]) begin
         t_above = {mag_z > {st.zh[6:0], st.zl[7:2]}, mag_y > {st.yh[6:0], st.yl[7:2]},
                    mag_x > {st.xh[6:0], st.xl[7:2]}};
      end else begin
         t_above = {mag_z > trans_scaled, mag_y > trans_scaled, mag_x > trans_scaled};
      end
      trans_now = |(t_above & axis_en);
   end

   // Register read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      case (paddr)
         `FFTH_ADDR(`FFTH_IDX_XH): rd_data = {24'h00_0000, st.xh};
         `FFTH_ADDR(`FFTH_IDX_XL): rd_data = {24'h00_0000, st.xl[7:2], 2'b00};
         `FFTH_ADDR(`FFTH_IDX_YH): rd_data = {24'h00_0000, st.yh};
         `FFTH_ADDR(`FFTH_IDX_YL): rd_data = {24'h00_0000, st.yl[7:2], 2'b00};
         `FFTH_ADDR(`FFTH_IDX_ZH): rd_data = {24'h00_0000, 1'b0, st.zh[6:0]};
         `FFTH_ADDR(`FFTH_IDX_ZL): rd_data = {24'h00_0000, st.zl[7:2], 2'b00};
         `FFTH_ADDR(`FFTH_IDX_CTRL): rd_data = {24'h00_0000, st.ctrl};
         `FFTH_ADDR(`FFTH_IDX_STAT): rd_data = {28'h000_0000, st.ffmt_cond, st.trans_cond, st.status};
         `FFTH_ADDR(`FFTH_IDX_MASK): rd_data = {30'h0000_0000, st.mask};
         `FFTH_ADDR(`FFTH_IDX_EVT): rd_data = {17'h0_0000, st.common_transient_threshold, 1'b0, st.common_ths};
         `FFTH_ADDR(`FFTH_IDX_COUNT): rd_data = {16'h0000, st.dbcnt, st.count};
         default: rd_hit = 1'b0;
      endcase
   end

   // Next-state logic: bus, sample evaluation, debounce, interrupts
   always_comb begin
      logic [1:0] evt;
      logic [1:0] w1c;
      evt = 2'b00;
      w1c = 2'b00;
      next_st = st;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      wr_en = 1'b0;
      case (st.bus)
         ffth_pkg::FFTH_IDLE: begin
            if (psel && !penable) begin
               next_st.bus = ffth_pkg::FFTH_SETUP;
            end
         end
         ffth_pkg::FFTH_SETUP: begin
            next_st.bus = ffth_pkg::FFTH_ACCESS;
            next_st.pready = 1'b1;
            next_st.pslverr = !rd_hit;
            next_st.prdata = pwrite ? 32'h0000_0000 : rd_data;
         end
         ffth_pkg::FFTH_ACCESS: begin
            wr_en = pwrite && rd_hit;
            next_st.bus = ffth_pkg::FFTH_IDLE;
         end
         default: next_st.bus = ffth_pkg::FFTH_IDLE;
      endcase
      if (wr_en) begin
         case (paddr)
            `FFTH_ADDR(`FFTH_IDX_XH): next_st.xh = pwdata[7:0];
            `FFTH_ADDR(`FFTH_IDX_XL): next_st.xl = {pwdata[7:2], 2'b00};
            `FFTH_ADDR(`FFTH_IDX_YH): next_st.yh = pwdata[7:0];
            `FFTH_ADDR(`FFTH_IDX_YL): next_st.yl = {pwdata[7:2], 2'b00};
            `FFTH_ADDR(`FFTH_IDX_ZH): next_st.zh = {1'b0, pwdata[6:0]};
            `FFTH_ADDR(`FFTH_IDX_ZL): next_st.zl = {pwdata[7:2], 2'b00};
            `FFTH_ADDR(`FFTH_IDX_CTRL): next_st.ctrl = pwdata[7:0];
            `FFTH_ADDR(`FFTH_IDX_STAT): w1c = pwdata[1:0];
            `FFTH_ADDR(`FFTH_IDX_MASK): next_st.mask = pwdata[1:0];
            `FFTH_ADDR(`FFTH_IDX_EVT): begin
               next_st.common_ths = pwdata[6:0];
               next_st.common_transient_threshold = pwdata[14:8];
            end
            `FFTH_ADDR(`FFTH_IDX_COUNT): next_st.count = pwdata[7:0];
            default: w1c = 2'b00;
         endcase
      end
      // One evaluation per sample
      if (sample_valid) begin
         next_st.ffmt_cond = ffmt_now;
         next_st.trans_cond = trans_now;
         evt[1] = trans_now;
         if (ffmt_now) begin
            if (st.dbcnt < st.count) begin
               next_st.dbcnt = st.dbcnt + 8'h01;
            end
         end else if (st.ctrl[`FFTH_CTRL_DBCM]) begin
            next_st.dbcnt = 8'h00;
         end else if (st.dbcnt != 8'h00) begin
            next_st.dbcnt = st.dbcnt - 8'h01;
         end
         // Event when the count is reached
         if (ffmt_now && (st.dbcnt >= st.count || st.dbcnt + 8'h01 >= st.count)) begin
            evt[0] = 1'b1;
         end
         next_st.ffmt_flag = evt[0];
      end
      // Set wins over write-one clear
      next_st.status = (st.status & ~w1c) | evt;
      next_st.irq = |(next_st.status & next_st.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.bus <= ffth_pkg::FFTH_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign ffmt_detect = st.ffmt_cond;
   assign transient_detect = st.trans_cond;
   assign ffmt_event = st.ffmt_flag;
   assign irq = st.irq;

   // Checks
   sel_common_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !st.xh[7] && (st.ctrl[3:1] == 3'b111) && !st.ctrl[0] && (mag_x >= common_scaled)
      |=> !ffmt_detect) else $error("common threshold not used");
   high_g_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && st.ctrl[0] && st.ctrl[1] && (mag_x > ths_x) |=> ffmt_detect)
      else $error("high-g event missed");
   low_g_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !st.ctrl[0] && st.ctrl[1] && (mag_x >= ths_x) |=> !ffmt_detect)
      else $error("low-g event false");
   per_axis_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.xh[7] |-> ths_x == {st.xh[6:0], st.xl[7:2]}) else $error("per-axis threshold wrong");
   trans_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && st.yh[7] && st.ctrl[1] && (mag_x > {st.xh[6:0], st.xl[7:2]}) |=> transient_detect)
      else $error("transient per-axis missed");
   debounce_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && ffmt_now && (st.dbcnt >= st.count) |=> ffmt_event && st.status[0])
      else $error("event flag not set");
   hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !sample_valid |=> $stable(ffmt_detect)) else $error("compare without sample");
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == |($past(next_st.status) & $past(next_st.mask))) else $error("irq mismatch");
   // Bus answer shape
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("ready longer than one cycle");
   error_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready) else $error("error without ready");
   // Common thresholds and their scaling, per-axis high-g, and low-g with no axis enabled
   zero_common_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !st.xh[7] && st.ctrl[0] && st.ctrl[1] && (st.common_ths == 7'h00) && (mag_x != 13'h0000)
      |=> ffmt_detect) else $error("zero common threshold not exceeded");
   trans_common_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !st.yh[7] && st.ctrl[1] && (mag_x > trans_scaled) |=> transient_detect)
      else $error("transient common missed");
   trans_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !st.yh[7] && (mag_x <= trans_scaled) && (mag_y <= trans_scaled) && (mag_z <= trans_scaled)
      |=> !transient_detect) else $error("transient false");
   per_axis_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && st.xh[7] && st.ctrl[0] && st.ctrl[1] && (mag_x > {st.xh[6:0], st.xl[7:2]})
      |=> ffmt_detect) else $error("per-axis high-g missed");
   no_axis_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !st.ctrl[0] && (st.ctrl[3:1] == 3'b000) |=> !ffmt_detect)
      else $error("low-g with no axis");
   // Register layout
   z_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      !st.zh[7]) else $error("reserved bit set");
   low_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st.xl[1:0] == 2'b00) && (st.yl[1:0] == 2'b00) && (st.zl[1:0] == 2'b00))
      else $error("unused low bits set");
   // Debounce counter and transient status
   dbcnt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && !ffmt_now && st.ctrl[4] |=> (st.dbcnt == 8'h00)) else $error("counter not cleared");
   trans_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      sample_valid && trans_now |=> st.status[1]) else $error("transient status not set");
endmodule // ffth_top
`default_nettype wire

/* verification/ffth_apb_host.sv */
// APB host model that programs the threshold block registers
`timescale 1ns/10ps
`default_nettype none
module ffth_apb_host (
   input wire logic pclk, // Bus clock
   output logic psel, // Select
   output logic penable, // Enable
   output logic pwrite, // Direction, high for write
   output logic [11:0] paddr, // Byte address
   output logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr // Error response
);
   // Bus idles with nothing selected
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // One transfer, held until pready is seen at an edge or 16 edges pass; callers never set both select bits
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge pclk);
         ok = (pready === 1'b1);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule // ffth_apb_host
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the threshold select and compare block
`timescale 1ns/10ps
`default_nettype none
`include "ffth_defines.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [1:0] sel;
      logic [12:0] thr;
      logic [13:0] x, y, z;
      logic ff, tr;
   } ffth_row_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic sample_valid = 1'b0;
   logic [13:0] ax = 14'h0000;
   logic [13:0] ay = 14'h0000;
   logic [13:0] az = 14'h0000;
   logic psel, penable, pwrite, pready, pslverr, e, ok;
   logic ffmt_detect, transient_detect, ffmt_event, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_count = 0;
   int n_tests = 0;
   ffth_row_type r;
   // Common thresholds: motion 4 steps, transient 8 steps
   ffth_row_type rows [11] = '{
      '{8'h0E, 2'd0, 13'd300, 14'd500, -14'sd500, 14'd500, 1'b1, 1'b0},
      '{8'h0E, 2'd0, 13'd300, 14'd500, 14'd0, -14'sd1500, 1'b0, 1'b0},
      '{8'h0F, 2'd0, 13'd300, 14'd600, 14'd0, 14'd0, 1'b0, 1'b0},
      '{8'h0F, 2'd0, 13'd300, -14'sd1500, 14'd0, 14'd3000, 1'b1, 1'b1},
      '{8'h2F, 2'd0, 13'd300, 14'd700, 14'd0, 14'd0, 1'b1, 1'b0},
      '{8'h0F, 2'd1, 13'd300, 14'd301, 14'd0, 14'd0, 1'b1, 1'b0},
      '{8'h0F, 2'd1, 13'd300, 14'd300, -14'sd300, 14'd0, 1'b0, 1'b0},
      '{8'h0E, 2'd1, 13'd300, 14'd299, -14'sd299, 14'd299, 1'b1, 1'b0},
      '{8'h0F, 2'd2, 13'd300, 14'd400, 14'd0, 14'd0, 1'b0, 1'b1},
      '{8'h0D, 2'd0, 13'd300, 14'd2000, 14'd0, 14'd0, 1'b0, 1'b0},
      '{8'h4F, 2'd1, 13'd300, 14'd301, 14'd0, 14'd0, 1'b1, 1'b0}
   };
   // 100 MHz clock
   always begin
      #5 pclk = ~pclk;
   end
   ffth_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ffth_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .accel_x(ax), .accel_y(ay), .accel_z(az), .ffmt_detect(ffmt_detect),
      .transient_detect(transient_detect), .ffmt_event(ffmt_event), .irq(irq));
   // Prints the counts and the verdict, then stops
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Register access by index; a transfer that never completes ends the run
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      host.xfer(w, `FFTH_ADDR(idx), d, q, e, ok);
      // Let the access edge's register and interrupt updates settle before callers look
      #1;
      if (ok !== 1'b1) begin
         err_count++;
         end_of_test();
      end
   endtask
   // One sample pulse; outputs are settled one edge later
   task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
      @(posedge pclk);
      sample_valid <= 1'b1;
      ax <= x;
      ay <= y;
      az <= z;
      @(posedge pclk);
      sample_valid <= 1'b0;
      #1;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, 8'h73 + k[7:0], 32'h0);
         `CHK("threshold reset value", 32'h0000_0000, q)
      end
      bus(1'b0, 8'h79, 32'h0);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0000_0000, q)
      $display("Reset and map test done");
      bus(1'b1, `FFTH_IDX_EVT, 32'h0000_0804);
      for (int i = 0; i < 11; i++) begin
         r = rows[i];
         bus(1'b1, `FFTH_IDX_CTRL, {24'h0, r.ctrl});
         bus(1'b1, `FFTH_IDX_XH, {24'h0, r.sel[0], r.thr[12:6]});
         bus(1'b1, `FFTH_IDX_YH, {24'h0, r.sel[1], r.thr[12:6]});
         bus(1'b1, `FFTH_IDX_ZH, {25'h0, r.thr[12:6]});
         for (int k = 0; k < 3; k++) begin
            bus(1'b1, 8'h74 + 8'(2 * k), {24'h0, r.thr[5:0], 2'b00});
         end
         smp(r.x, r.y, r.z);
         `CHK("ffmt_detect", r.ff, ffmt_detect)
         `CHK("transient_detect", r.tr, transient_detect)
         `CHK("ffmt_event", r.ff, ffmt_event)
         $display("Row %0d done", i);
      end
      bus(1'b1, `FFTH_IDX_CTRL, 32'h0000_000E);
      `CHK("detect held", 1'b1, ffmt_detect)
      smp(14'd301, 14'd0, 14'd0);
      `CHK("detect new sample", 1'b0, ffmt_detect)
      $display("Sample timing test done");
      bus(1'b1, `FFTH_IDX_COUNT, 32'h0000_0002);
      bus(1'b1, `FFTH_IDX_CTRL, 32'h0000_001F);
      smp(14'd400, 14'd0, 14'd0);
      `CHK("event first", 1'b0, ffmt_event)
      smp(14'd400, 14'd0, 14'd0);
      `CHK("event second", 1'b1, ffmt_event)
      $display("Debounce test done");
      bus(1'b0, `FFTH_IDX_STAT, 32'h0);
      `CHK("status sticky", 1'b1, q[0])
      `CHK("irq masked", 1'b0, irq)
      bus(1'b1, `FFTH_IDX_MASK, 32'h0000_0001);
      `CHK("irq unmasked", 1'b1, irq)
      bus(1'b1, `FFTH_IDX_STAT, 32'h0000_0003);
      `CHK("irq cleared", 1'b0, irq)
      $display("Interrupt test done");
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
